// ### design/slf_pkg.sv
package slf_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LOOP_PHASE_CONTROL       = 8'h23;
  localparam logic [7:0] ADDR_FILTER_SERIES_RESISTANCE = 8'h24;
  localparam logic [7:0] ADDR_FILTER_MAIN_CAPACITANCE  = 8'h25;
  localparam logic [7:0] ADDR_FILTER_POLE_RESISTANCE   = 8'h26;
  localparam logic [7:0] ADDR_FILTER_POLE_CAPACITANCE  = 8'h27;
  localparam logic [7:0] ADDR_CALIBRATION_WAIT_CONTROL = 8'h2A;
  localparam logic [7:0] ADDR_NONVOLATILE_CONTROL      = 8'h31;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PUMP_PHASE_LSB    = 4;
  localparam int PUMP_PHASE_MSB    = 6;
  localparam int THIRD_POLE_BIT    = 2;
  localparam int CLSD_WAIT_LSB     = 2;
  localparam int CLSD_WAIT_MSB     = 3;
  localparam int OSC_WAIT_LSB      = 0;
  localparam int OSC_WAIT_MSB      = 1;
  localparam int LOAD_TRIGGER_BIT  = 3;

  // Writable bits of each register; the rest read as zero
  localparam logic [7:0] LOOP_MASK   = 8'h77;
  localparam logic [7:0] SERIES_MASK = 8'hFF;
  localparam logic [7:0] MAINC_MASK  = 8'h07;
  localparam logic [7:0] POLER_MASK  = 8'h7F;
  localparam logic [7:0] POLEC_MASK  = 8'h07;
  localparam logic [7:0] CAL_MASK    = 8'h0F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LOOP_RST   = 8'h03;
  localparam logic [7:0] SERIES_RST = 8'h08;
  localparam logic [7:0] MAINC_RST  = 8'h00;
  localparam logic [7:0] POLER_RST  = 8'h00;
  localparam logic [7:0] POLEC_RST  = 8'h00;
  localparam logic [7:0] CAL_RST    = 8'h09;

  // Number of registers restored from non-volatile memory
  localparam int          NV_REGS  = 6;
  localparam logic [2:0]  NV_LAST  = 3'h5;

  // ----------------------------------------------------------------
  // Settle timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 20000;
  localparam int CNT_W   = 18;
  localparam int OSC_US0  = 20;
  localparam int OSC_US1  = 400;
  localparam int OSC_US2  = 4000;
  localparam int OSC_US3  = 10000;
  localparam int CLSD_US0 = 150;
  localparam int CLSD_US1 = 300;
  localparam int CLSD_US2 = 500;
  localparam int CLSD_US3 = 2000;
  localparam int OSC_CYC0  = OSC_US0 * CLK_KHZ / 1000;
  localparam int OSC_CYC1  = OSC_US1 * CLK_KHZ / 1000;
  localparam int OSC_CYC2  = OSC_US2 * CLK_KHZ / 1000;
  localparam int OSC_CYC3  = OSC_US3 * CLK_KHZ / 1000;
  localparam int CLSD_CYC0 = CLSD_US0 * CLK_KHZ / 1000;
  localparam int CLSD_CYC1 = CLSD_US1 * CLK_KHZ / 1000;
  localparam int CLSD_CYC2 = CLSD_US2 * CLK_KHZ / 1000;
  localparam int CLSD_CYC3 = CLSD_US3 * CLK_KHZ / 1000;

  // Calibration sequencer states
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_OSC,
    CAL_CLSD
  } slf_cal_e;

endpackage

// ### design/slf_settle_if.sv
`timescale 1ns/1ps
interface slf_settle_if;
  import slf_pkg::*;

  logic             load;
  logic [CNT_W-1:0] load_count;
  logic             done;

  modport ctl (output load, output load_count, input done);
  modport tmr (input load, input load_count, output done);
endinterface

// ### design/slf_settle_timer.sv
`timescale 1ns/1ps
module slf_settle_timer
  import slf_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  slf_settle_if.tmr tmr
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             done;
  } slf_tmr_s;

  slf_tmr_s cur;
  slf_tmr_s nxt;

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  // Done pulses one cycle after the count reaches one, so an interval
  // never ends early
  always_comb
  begin
    nxt      = cur;
    nxt.done = 1'b0;
    if (tmr.load)
    begin
      nxt.count = tmr.load_count;
    end
    else if (cur.count != '0)
    begin
      nxt.count = cur.count - 1'b1;
      nxt.done  = (cur.count == CNT_W'(1));
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cur <= '0;
    else
      cur <= nxt;
  end

  assign tmr.done = cur.done;

endmodule

// ### design/slf_loop_regs.sv
`timescale 1ns/1ps
// Contract
// - Pump phase offset: loop control bits 6:4, read-write, resets to zero.
// - Codes 1-3 select delays for 100 MHz detector, 4-7 for 50 MHz.
// - Loop control bit 2 enables third pole capacitor, resets to 0.
// - Series resistance is a full 8-bit read-write code, resetting to 0x08.
// - Main capacitance code bits 2:0, read-write, reset zero; 5 pF + 50 pF per step.
// - Pole resistance code bits 6:0, read-write, resets to 0x00.
// - Pole capacitance code bits 2:0, read-write, reset zero; 5 pF per step.
// - Closed-loop settle wait bits 3:2, resets 0x2; 150/300/500/2000 us.
// - Oscillator settle wait bits 1:0, resets 0x1; 20/400/4000/10000 us.
// - Reset or load trigger copies non-volatile contents; trigger self-clears; reads blocked.
module slf_loop_regs
  import slf_pkg::*;
#(
  parameter int unsigned OSC_CYCLES0  = OSC_CYC0,
  parameter int unsigned OSC_CYCLES1  = OSC_CYC1,
  parameter int unsigned OSC_CYCLES2  = OSC_CYC2,
  parameter int unsigned OSC_CYCLES3  = OSC_CYC3,
  parameter int unsigned CLSD_CYCLES0 = CLSD_CYC0,
  parameter int unsigned CLSD_CYCLES1 = CLSD_CYC1,
  parameter int unsigned CLSD_CYCLES2 = CLSD_CYC2,
  parameter int unsigned CLSD_CYCLES3 = CLSD_CYC3
)
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic            reg_busy,
  output logic            nv_req,
  output logic      [2:0] nv_index,
  input  wire logic       nv_ack,
  input  wire logic [7:0] nv_data,
  input  wire logic       cal_start,
  output logic            cal_busy,
  output logic            loop_settled,
  output logic      [2:0] pump_phase_offset,
  output logic            third_pole_cap_enable,
  output logic      [7:0] series_resistance_code,
  output logic      [2:0] main_capacitance_code,
  output logic      [6:0] pole_resistance_code,
  output logic      [2:0] pole_capacitance_code,
  output logic      [1:0] closed_loop_settle_wait,
  output logic      [1:0] oscillator_settle_wait
);

  typedef struct packed {
    logic [7:0]       loop_ctl;
    logic [7:0]       series_r;
    logic [7:0]       main_c;
    logic [7:0]       pole_r;
    logic [7:0]       pole_c;
    logic [7:0]       cal_ctl;
    logic             load_trigger;
    logic             copying;
    logic [2:0]       copy_idx;
    logic             nv_req;
    logic [7:0]       rdata;
    logic             rvalid;
    slf_cal_e         cal_state;
    logic             tmr_load;
    logic [CNT_W-1:0] tmr_count;
    logic             settled;
    logic             cal_busy;
  } slf_regs_s;

  slf_regs_s cur;
  slf_regs_s next_st;

  slf_settle_if settle ();

  // ----------------------------------------------------------------
  // Settle interval lookup
  // ----------------------------------------------------------------
  // Parameters allow a simulation to shrink the long intervals
  function automatic logic [CNT_W-1:0] osc_cycles(input logic [1:0] code);
    logic [CNT_W-1:0] c;
    unique case (code)
      2'h0: c = CNT_W'(OSC_CYCLES0);
      2'h1: c = CNT_W'(OSC_CYCLES1);
      2'h2: c = CNT_W'(OSC_CYCLES2);
      2'h3: c = CNT_W'(OSC_CYCLES3);
    endcase
    return c;
  endfunction

  function automatic logic [CNT_W-1:0] clsd_cycles(input logic [1:0] code);
    logic [CNT_W-1:0] c;
    unique case (code)
      2'h0: c = CNT_W'(CLSD_CYCLES0);
      2'h1: c = CNT_W'(CLSD_CYCLES1);
      2'h2: c = CNT_W'(CLSD_CYCLES2);
      2'h3: c = CNT_W'(CLSD_CYCLES3);
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Register write helper
  // ----------------------------------------------------------------
  // Same path serves host writes and the non-volatile copy; reserved
  // bits are masked off so they always read back as zero
  function automatic slf_regs_s store(input slf_regs_s s, input logic [7:0] addr,
                                      input logic [7:0] d);
    slf_regs_s r;
    r = s;
    unique case (addr)
      ADDR_LOOP_PHASE_CONTROL:       r.loop_ctl = d & LOOP_MASK;
      ADDR_FILTER_SERIES_RESISTANCE: r.series_r = d & SERIES_MASK;
      ADDR_FILTER_MAIN_CAPACITANCE:  r.main_c   = d & MAINC_MASK;
      ADDR_FILTER_POLE_RESISTANCE:   r.pole_r   = d & POLER_MASK;
      ADDR_FILTER_POLE_CAPACITANCE:  r.pole_c   = d & POLEC_MASK;
      ADDR_CALIBRATION_WAIT_CONTROL: r.cal_ctl  = d & CAL_MASK;
      default:                       r = s;
    endcase
    return r;
  endfunction

  // Copy order follows the register offsets; indexes 6 and 7 never
  // occur, so they map to no register
  function automatic logic [7:0] copy_addr(input logic [2:0] idx);
    logic [7:0] a;
    unique case (idx)
      3'h0:    a = ADDR_LOOP_PHASE_CONTROL;
      3'h1:    a = ADDR_FILTER_SERIES_RESISTANCE;
      3'h2:    a = ADDR_FILTER_MAIN_CAPACITANCE;
      3'h3:    a = ADDR_FILTER_POLE_RESISTANCE;
      3'h4:    a = ADDR_FILTER_POLE_CAPACITANCE;
      3'h5:    a = ADDR_CALIBRATION_WAIT_CONTROL;
      default: a = 8'h00;
    endcase
    return a;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st          = cur;
    next_st.rvalid   = 1'b0;
    next_st.tmr_load = 1'b0;

    // Non-volatile copy; host writes are dropped so the restored image
    // cannot be half overwritten
    if (cur.copying)
    begin
      if (nv_ack)
      begin
        next_st = store(next_st, copy_addr(cur.copy_idx), nv_data);
        if (cur.copy_idx == NV_LAST)
        begin
          next_st.copying      = 1'b0;
          next_st.nv_req       = 1'b0;
          next_st.load_trigger = 1'b0;
        end
        else
        begin
          next_st.copy_idx = cur.copy_idx + 3'h1;
        end
      end
    end
    // Host write; a load trigger starts a fresh copy
    else if (reg_wr)
    begin
      next_st = store(next_st, reg_addr, reg_wdata);
      if (reg_addr == ADDR_NONVOLATILE_CONTROL && reg_wdata[LOAD_TRIGGER_BIT])
      begin
        next_st.load_trigger = 1'b1;
        next_st.copying      = 1'b1;
        next_st.copy_idx     = 3'h0;
        next_st.nv_req       = 1'b1;
      end
    end

    // Register read; refused while the copy runs, and a refused read
    // leaves reg_rdata holding the last answer
    if (reg_rd && !cur.copying)
    begin
      next_st.rvalid = 1'b1;
      unique case (reg_addr)
        ADDR_LOOP_PHASE_CONTROL:       next_st.rdata = cur.loop_ctl;
        ADDR_FILTER_SERIES_RESISTANCE: next_st.rdata = cur.series_r;
        ADDR_FILTER_MAIN_CAPACITANCE:  next_st.rdata = cur.main_c;
        ADDR_FILTER_POLE_RESISTANCE:   next_st.rdata = cur.pole_r;
        ADDR_FILTER_POLE_CAPACITANCE:  next_st.rdata = cur.pole_c;
        ADDR_CALIBRATION_WAIT_CONTROL: next_st.rdata = cur.cal_ctl;
        ADDR_NONVOLATILE_CONTROL:
          next_st.rdata = {4'h0, cur.load_trigger, 3'h0};
        default:                       next_st.rdata = 8'h00;
      endcase
    end

    // Calibration: oscillator settle first, then closed-loop settle
    unique case (cur.cal_state)
      CAL_IDLE:
      begin
        if (cal_start && !cur.copying)
        begin
          next_st.settled   = 1'b0;
          next_st.cal_state = CAL_OSC;
          next_st.tmr_load  = 1'b1;
          next_st.tmr_count =
            osc_cycles(cur.cal_ctl[OSC_WAIT_MSB:OSC_WAIT_LSB]);
        end
      end
      CAL_OSC:
      begin
        if (settle.done)
        begin
          next_st.cal_state = CAL_CLSD;
          next_st.tmr_load  = 1'b1;
          next_st.tmr_count =
            clsd_cycles(cur.cal_ctl[CLSD_WAIT_MSB:CLSD_WAIT_LSB]);
        end
      end
      CAL_CLSD:
      begin
        if (settle.done)
        begin
          next_st.cal_state = CAL_IDLE;
          next_st.settled   = 1'b1;
        end
      end
      // Unused code; fall back to idle rather than hang the sequencer
      default:
      begin
        next_st.cal_state = CAL_IDLE;
      end
    endcase

    // Busy kept as its own flop so the output is no decode
    next_st.cal_busy = (next_st.cal_state != CAL_IDLE);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset loads the default image, then a copy starts at once;
  // the reset branch holds constants only
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cur           <= '0;
      cur.loop_ctl  <= LOOP_RST;
      cur.series_r  <= SERIES_RST;
      cur.main_c    <= MAINC_RST;
      cur.pole_r    <= POLER_RST;
      cur.pole_c    <= POLEC_RST;
      cur.cal_ctl   <= CAL_RST;
      cur.copying   <= 1'b1;
      cur.nv_req    <= 1'b1;
      cur.cal_state <= CAL_IDLE;
      cur.cal_busy  <= 1'b0;
    end
    else
    begin
      cur <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Settle timer
  // ----------------------------------------------------------------
  // Load is a one-cycle pulse from the sequencer
  assign settle.load       = cur.tmr_load;
  assign settle.load_count = cur.tmr_count;

  // One timer serves both waits; the sequencer reloads it between phases
  slf_settle_timer u_timer (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tmr     (settle.tmr)
  );

  // ----------------------------------------------------------------
  // Outputs, all straight from state flops
  // ----------------------------------------------------------------
  assign reg_rdata               = cur.rdata;
  assign reg_rvalid              = cur.rvalid;
  assign reg_busy                = cur.copying;
  assign nv_req                  = cur.nv_req;
  assign nv_index                = cur.copy_idx;
  assign cal_busy                = cur.cal_busy;
  assign loop_settled            = cur.settled;
  // Analog decodes the delay tables from these codes
  assign pump_phase_offset       = cur.loop_ctl[PUMP_PHASE_MSB:PUMP_PHASE_LSB];
  assign third_pole_cap_enable   = cur.loop_ctl[THIRD_POLE_BIT];
  assign series_resistance_code  = cur.series_r;
  assign main_capacitance_code   = cur.main_c[2:0];
  assign pole_resistance_code    = cur.pole_r[6:0];
  assign pole_capacitance_code   = cur.pole_c[2:0];
  assign closed_loop_settle_wait = cur.cal_ctl[CLSD_WAIT_MSB:CLSD_WAIT_LSB];
  assign oscillator_settle_wait  = cur.cal_ctl[OSC_WAIT_MSB:OSC_WAIT_LSB];

endmodule

// ### verification/slf_loop_regs_asserts.sv
`timescale 1ns/1ps
module slf_loop_regs_asserts
  import slf_pkg::*;
#(
  parameter int unsigned OSC_CYCLES3  = OSC_CYC3,
  parameter int unsigned CLSD_CYCLES3 = CLSD_CYC3
)
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rvalid,
  input wire logic       reg_busy,
  input wire logic       nv_req,
  input wire logic [2:0] nv_index,
  input wire logic       nv_ack,
  input wire logic       cal_start,
  input wire logic       cal_busy,
  input wire logic       loop_settled,
  input wire logic [2:0] pump_phase_offset,
  input wire logic       third_pole_cap_enable,
  input wire logic [7:0] series_resistance_code,
  input wire logic [1:0] closed_loop_settle_wait,
  input wire logic [1:0] oscillator_settle_wait
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [CNT_W:0] cal_cnt;
  logic           wr_ok;

  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // Length of the current calibration; too long for a repetition
  always_ff @(posedge clk_sys)
    cal_cnt <= (rst || !cal_busy) ? '0 : cal_cnt + 1'b1;
  assign wr_ok = reg_wr && !reg_busy;

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_read_answer; reg_rd && !reg_busy |=> reg_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_read_refused; reg_rd && reg_busy |=> !reg_rvalid; endproperty
  a_read_refused: assert property (p_read_refused) else $error("read answered while copying");
  property p_loop_write; wr_ok && reg_addr == ADDR_LOOP_PHASE_CONTROL
    |=> {1'b0, pump_phase_offset, 1'b0, third_pole_cap_enable, 2'h0} == ($past(reg_wdata) & 8'h74); endproperty
  a_loop_write: assert property (p_loop_write) else $error("loop control codes wrong");
  property p_series_write; wr_ok && reg_addr == ADDR_FILTER_SERIES_RESISTANCE
    |=> series_resistance_code == $past(reg_wdata); endproperty
  a_series_write: assert property (p_series_write) else $error("series code wrong");
  property p_cal_write; wr_ok && reg_addr == ADDR_CALIBRATION_WAIT_CONTROL
    |=> {4'h0, closed_loop_settle_wait, oscillator_settle_wait} == ($past(reg_wdata) & 8'h0F); endproperty
  a_cal_write: assert property (p_cal_write) else $error("settle wait codes wrong");
  property p_cal_start; cal_start && !cal_busy && !reg_busy |=> cal_busy && !loop_settled; endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration did not start");
  property p_settle_end; $fell(cal_busy) |-> loop_settled; endproperty
  a_settle_end: assert property (p_settle_end) else $error("wait ended unsettled");
  property p_cal_bound; cal_cnt <= OSC_CYCLES3 + CLSD_CYCLES3 + 8; endproperty
  a_cal_bound: assert property (p_cal_bound) else $error("calibration too long");
  property p_trigger; wr_ok && reg_addr == ADDR_NONVOLATILE_CONTROL && reg_wdata[LOAD_TRIGGER_BIT]
    |=> reg_busy && nv_req && nv_index == 3'h0; endproperty
  a_trigger: assert property (p_trigger) else $error("load trigger ignored");
  property p_index_step; nv_req && nv_ack && nv_index < NV_LAST
    |=> nv_index == $past(nv_index) + 3'h1; endproperty
  a_index_step: assert property (p_index_step) else $error("copy index did not step");
endmodule

bind slf_loop_regs slf_loop_regs_asserts #(.OSC_CYCLES3(OSC_CYCLES3), .CLSD_CYCLES3(CLSD_CYCLES3)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .reg_busy(reg_busy), .nv_req(nv_req),
  .nv_index(nv_index), .nv_ack(nv_ack), .cal_start(cal_start), .cal_busy(cal_busy),
  .loop_settled(loop_settled), .pump_phase_offset(pump_phase_offset),
  .third_pole_cap_enable(third_pole_cap_enable), .series_resistance_code(series_resistance_code),
  .closed_loop_settle_wait(closed_loop_settle_wait), .oscillator_settle_wait(oscillator_settle_wait));

// ### verification/slf_nv_model.sv
`timescale 1ns/1ps
module slf_nv_model
  import slf_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       nv_req,
  input  wire logic [2:0] nv_index,
  input  wire logic       alt,
  input  wire logic       slow,
  output logic            nv_ack = 1'b0,
  output logic      [7:0] nv_data = 8'h5A
);
  localparam logic [7:0] IMG [6] = '{8'h03, 8'h08, 8'h00, 8'h00, 8'h00, 8'h09};
  logic [2:0] wait_cnt = 3'h0;

  // ------------------------------------------------------------
  // Store answer
  // ------------------------------------------------------------
  // Data churns between answers so a stale byte is never read back
  always @(posedge clk_sys)
  begin
    nv_ack  <= 1'b0;
    nv_data <= ~nv_data;
    if (rst || !nv_req || nv_ack)
      wait_cnt <= 3'h0;
    else if (wait_cnt >= (slow ? 3'h3 : 3'h0))
    begin
      nv_ack   <= 1'b1;
      nv_data  <= alt ? 8'hFF : IMG[nv_index];
      wait_cnt <= 3'h0;
    end
    else
      wait_cnt <= wait_cnt + 3'h1;
  end
endmodule

// ### verification/tb_slf_loop_regs.sv
`timescale 1ns/1ps
module tb_slf_loop_regs
  import slf_pkg::*;
;
  localparam int OC [4] = '{4, 8, 12, 16};
  localparam int CC [4] = '{5, 11, 17, 23};
  localparam logic [7:0] AD [6] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2A};
  localparam logic [7:0] RV [6] = '{8'h03, 8'h08, 8'h00, 8'h00, 8'h00, 8'h09};
  localparam logic [7:0] MK [6] = '{8'h77, 8'hFF, 8'h07, 8'h7F, 8'h07, 8'h0F};
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        cal_start = 1'b0;
  logic        alt = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic        reg_busy;
  logic        nv_req;
  logic [2:0]  nv_index;
  logic        nv_ack;
  logic [7:0]  nv_data;
  logic        cal_busy;
  logic        loop_settled;
  logic [2:0]  pump_phase_offset;
  logic        third_pole_cap_enable;
  logic [7:0]  series_resistance_code;
  logic [2:0]  main_capacitance_code;
  logic [6:0]  pole_resistance_code;
  logic [2:0]  pole_capacitance_code;
  logic [1:0]  closed_loop_settle_wait;
  logic [1:0]  oscillator_settle_wait;
  logic [7:0]  sh [6];
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n;
  int          e;
  int          o;
  int          c;
  wire  [31:0] codes = {3'h0, pump_phase_offset, third_pole_cap_enable, series_resistance_code,
    main_capacitance_code, pole_resistance_code, pole_capacitance_code, closed_loop_settle_wait,
    oscillator_settle_wait};

  always #25 clk_sys = ~clk_sys;

  slf_loop_regs #(.OSC_CYCLES0(OC[0]), .OSC_CYCLES1(OC[1]), .OSC_CYCLES2(OC[2]), .OSC_CYCLES3(OC[3]),
    .CLSD_CYCLES0(CC[0]), .CLSD_CYCLES1(CC[1]), .CLSD_CYCLES2(CC[2]), .CLSD_CYCLES3(CC[3])) u_slf_loop_regs (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_busy(reg_busy),
    .nv_req(nv_req), .nv_index(nv_index), .nv_ack(nv_ack), .nv_data(nv_data), .cal_start(cal_start),
    .cal_busy(cal_busy), .loop_settled(loop_settled), .pump_phase_offset(pump_phase_offset),
    .third_pole_cap_enable(third_pole_cap_enable), .series_resistance_code(series_resistance_code),
    .main_capacitance_code(main_capacitance_code), .pole_resistance_code(pole_resistance_code),
    .pole_capacitance_code(pole_capacitance_code), .closed_loop_settle_wait(closed_loop_settle_wait),
    .oscillator_settle_wait(oscillator_settle_wait));

  slf_nv_model u_slf_nv_model (.clk_sys(clk_sys), .rst(rst), .nv_req(nv_req), .nv_index(nv_index),
    .alt(alt), .slow(slow), .nv_ack(nv_ack), .nv_data(nv_data));

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Answer is registered on the taking edge, so look just past it
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic ans);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check({31'h0, reg_rvalid}, {31'h0, ans});
    if (ans)
      check({24'h0, reg_rdata}, {24'h0, exp});
  endtask

  // Every register but the non-volatile control against the shadow, then the code outputs
  task automatic all_regs();
    for (int i = 0; i < 6; i++)
      rd(AD[i], sh[i], 1'b1);
    check(codes, {3'h0, sh[0][6:4], sh[0][2], sh[1], sh[2][2:0], sh[3][6:0], sh[4][2:0],
      sh[5][3:0]});
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 100 && reg_busy !== 1'b0; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    check({31'h0, reg_busy}, 32'h0);
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  // Watchdog; the whole run needs well under 2000 cycles
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check({31'h0, reg_busy}, 32'h1);
    wait_idle();
    sh = RV;
    all_regs();
    // Every writable bit set; reserved bits as the host must write them
    for (int i = 0; i < 6; i++)
      wr(AD[i], MK[i]);
    wr(8'h28, 8'hFF);
    sh = MK;
    all_regs();
    rd(8'h28, 8'h00, 1'b1);
    // Every pump code, third pole toggling, writable low pair (bits 1:0) kept at 3
    for (int k = 0; k < 8; k++)
    begin
      sh[0] = {1'b0, 3'(k), 1'b0, 1'(k), 2'h3};
      wr(AD[0], sh[0]);
      all_regs();
    end
    // Each wait code, plus one mixed pair (oscillator 3, closed-loop 0); a second start mid-wait is ignored
    for (int k = 0; k < 5; k++)
    begin
      o = (k == 4) ? 3 : k;
      c = (k == 4) ? 0 : k;
      wr(AD[5], {4'h0, 2'(c), 2'(o)});
      @(posedge clk_sys);
      cal_start <= 1'b1;
      @(posedge clk_sys);
      cal_start <= 1'b0;
      @(posedge clk_sys);
      #1;
      n = 1;
      while (loop_settled !== 1'b1 && n < 100)
      begin
        @(posedge clk_sys);
        cal_start <= (n == 3);
        n++;
        #1;
      end
      e = OC[o] + CC[c] + 5;
      check(32'(n >= e - 2 && n <= e + 2), 32'h1);
    end
    // Reload from store with slow answers and an all-ones image
    @(posedge clk_sys);
    alt  <= 1'b1;
    slow <= 1'b1;
    wr(ADDR_NONVOLATILE_CONTROL, 8'h08);
    #1;
    check({31'h0, reg_busy}, 32'h1);
    rd(AD[1], 8'h00, 1'b0);
    wait_idle();
    sh = MK;
    all_regs();
    rd(ADDR_NONVOLATILE_CONTROL, 8'h00, 1'b1);
    report_and_stop();
  end
endmodule
